/* File: uis_pkg.sv */
// Constants and register map of the USART interrupt and status block
package uis_pkg;

  // Byte offsets of the register words
  localparam logic [7:0] UIS_OFS_CTRL = 8'h00;
  localparam logic [7:0] UIS_OFS_MODE = 8'h04;
  localparam logic [7:0] UIS_OFS_IER = 8'h08;
  localparam logic [7:0] UIS_OFS_IDR = 8'h0c;
  localparam logic [7:0] UIS_OFS_IMR = 8'h10;
  localparam logic [7:0] UIS_OFS_CSR = 8'h14;
  localparam logic [7:0] UIS_OFS_RTOR = 8'h24;

  // Command bits of the control register
  localparam int UIS_CR_RXEN = 4;
  localparam int UIS_CR_RXDIS = 5;
  localparam int UIS_CR_TXEN = 6;
  localparam int UIS_CR_TXDIS = 7;
  localparam int UIS_CR_CLR_ERR = 8;
  localparam int UIS_CR_BEGIN_BRK = 9;
  localparam int UIS_CR_ARM_IDLE = 11;
  localparam int UIS_CR_CLR_RETRY = 13;
  localparam int UIS_CR_CLR_CARD_SEEN_A = 14;

  // Mode register fields
  localparam int UIS_MR_FILTER = 28;
  localparam logic [3:0] UIS_MODE_ISO_T0 = 4'h4;
  localparam logic [3:0] UIS_MODE_ISO_T1 = 4'h6;

  // Status bit positions, shared by enable, disable, mask and status
  localparam int UIS_ST_RX_RDY = 0;
  localparam int UIS_ST_TX_FREE = 1;
  localparam int UIS_ST_BRK = 2;
  localparam int UIS_ST_RX_END = 3;
  localparam int UIS_ST_TX_END = 4;
  localparam int UIS_ST_OVR = 5;
  localparam int UIS_ST_FRAME = 6;
  localparam int UIS_ST_PAR = 7;
  localparam int UIS_ST_TIMEOUT = 8;
  localparam int UIS_ST_TX_EMPTY = 9;
  localparam int UIS_ST_ITER = 10;
  localparam int UIS_ST_TX_BUFE = 11;
  localparam int UIS_ST_RX_BUFF = 12;
  localparam int UIS_ST_CARD_SEEN_A = 13;
  localparam int UIS_ST_CHG_LO = 16;
  localparam int UIS_ST_LVL_LO = 20;

  // Bits that exist in the mask register
  localparam logic [31:0] UIS_IRQ_BITS = 32'h000f_3fff;

  // Reset values
  localparam logic [31:0] UIS_RST_MASK = 32'h0000_0000;
  localparam logic [31:0] UIS_RST_MODE = 32'h0000_0000;
  localparam logic [15:0] UIS_RST_RTO = 16'h0000;
  localparam logic [2:0] UIS_RST_SAMPLES = 3'h7;

endpackage : uis_pkg

/* File: uis_usart_irq_status.sv */
// Interrupt, mask and channel status logic of the USART, Avalon-MM slave
module uis_usart_irq_status
  import uis_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  // Avalon-MM slave, byte address
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Events and levels from the character engines
  input wire logic rx_char_done,
  input wire logic rx_holding_read,
  input wire logic rx_break_seen_evt,
  input wire logic rx_overrun_evt,
  input wire logic rx_frame_evt,
  input wire logic rx_parity_evt,
  input wire logic rx_timeout_evt,
  input wire logic iter_max_evt,
  input wire logic card_card_seen_a_evt,
  input wire logic tx_holding_full,
  input wire logic tx_shift_busy,
  input wire logic break_started,
  input wire logic sample_tick,
  // Peripheral DMA channel signals
  input wire logic rx_dma_end,
  input wire logic tx_dma_end,
  input wire logic tx_dma_buf_empty,
  input wire logic rx_dma_buf_full,
  // Pins from the serial peer
  input wire logic rx_line_pin,
  input wire logic ring_line_pin,
  input wire logic set_ready_pin,
  input wire logic carrier_pin,
  input wire logic clear_send_pin,
  // Outputs to the engines and the system
  output logic rx_line_filtered,
  output logic rx_enabled,
  output logic tx_enabled,
  output logic begin_break_cmd,
  output logic arm_idle_wait_cmd,
  output logic clear_retry_count_cmd,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////
  // Declarations

  logic wr_go; // Write takes effect
  logic rd_go; // Read completes
  logic [31:0] wmask; // Byte lanes of the write
  logic [31:0] wbits; // Write data gated by lanes
  logic [31:0] irq_mask; // Interrupt enables
  logic [31:0] mode_reg; // Mode register
  logic [15:0] idle_limit; // Time-out value
  logic [31:0] status_word; // Assembled status
  logic [31:0] next_rdata; // Read mux result
  logic cmd_wr; // Control register write
  logic [3:0] modem_meta; // First synchroniser stage
  logic [3:0] modem_sync; // Synchronised modem levels
  logic [3:0] modem_prev; // Previous synchronised levels
  logic [3:0] modem_chg; // Change flags
  logic rx_meta; // First rx stage
  logic rx_sync; // Synchronised rx line
  logic [2:0] rx_samples; // Last three sub-bit samples
  logic rx_major; // Two-of-three vote
  logic rx_rdy; // Receive ready flag
  logic rx_missed; // Chars arrived while receiver off
  logic brk_flag;
  logic ovr_flag;
  logic frame_flag;
  logic par_flag;
  logic tmo_flag;
  logic tmo_armed; // Waiting after an arm command
  logic iter_flag;
  logic card_seen_a_flag;
  logic break_pend; // Break requested, not yet started
  logic iso_mode; // Smart-card protocol selected
  logic clr_err; // Reset-status command this edge

  ////////////////////////////////////////////////////////////////////
  // Bus handshake

  // A held request is taken on the edge where waitrequest is already low
  assign wr_go = avs_write & ~avs_waitrequest;
  assign rd_go = avs_read & ~avs_waitrequest;

  // Lane expansion of byteenable
  assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  assign wbits = avs_writedata & wmask;
  assign cmd_wr = wr_go & (avs_address == UIS_OFS_CTRL);

  // Low for one cycle per request, high again at the completing edge
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      avs_waitrequest <= 1'b1;
    end
    else
    begin
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
    end
  end

  // Read data mux; unmapped and write-only words read as zero
  always_comb
  begin
    case (avs_address)
      UIS_OFS_MODE: next_rdata = mode_reg;
      UIS_OFS_IMR: next_rdata = irq_mask;
      UIS_OFS_CSR: next_rdata = status_word;
      UIS_OFS_RTOR: next_rdata = {16'h0000, idle_limit};
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // Read data is loaded in the wait cycle and stands at completion
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      avs_readdata <= 32'h0000_0000;
    end
    else if (avs_read & avs_waitrequest)
    begin
      avs_readdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Configuration registers

  // Mode register, byte-lane writes
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      mode_reg <= UIS_RST_MODE;
    end
    else if (wr_go & (avs_address == UIS_OFS_MODE))
    begin
      mode_reg <= (mode_reg & ~wmask) | wbits;
    end
  end

  // Time-out value
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      idle_limit <= UIS_RST_RTO;
    end
    else if (wr_go & (avs_address == UIS_OFS_RTOR))
    begin
      idle_limit <= (idle_limit & ~wmask[15:0]) | wbits[15:0];
    end
  end

  assign iso_mode = (mode_reg[3:0] == UIS_MODE_ISO_T0) |
                    (mode_reg[3:0] == UIS_MODE_ISO_T1);

  // Interrupt mask; set and clear sit at different addresses
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      irq_mask <= UIS_RST_MASK;
    end
    else if (wr_go & (avs_address == UIS_OFS_IER))
    begin
      irq_mask <= irq_mask | (wbits & UIS_IRQ_BITS);
    end
    else if (wr_go & (avs_address == UIS_OFS_IDR))
    begin
      irq_mask <= irq_mask & ~(wbits & UIS_IRQ_BITS);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Commands

  // Receiver and transmitter enables; disable wins over enable
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      rx_enabled <= 1'b0;
      tx_enabled <= 1'b0;
    end
    else if (cmd_wr)
    begin
      rx_enabled <= ~wbits[UIS_CR_RXDIS] & (wbits[UIS_CR_RXEN] | rx_enabled);
      tx_enabled <= ~wbits[UIS_CR_TXDIS] & (wbits[UIS_CR_TXEN] | tx_enabled);
    end
  end

  // One-cycle command strobes to the engines
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      begin_break_cmd <= 1'b0;
      arm_idle_wait_cmd <= 1'b0;
      clear_retry_count_cmd <= 1'b0;
    end
    else
    begin
      begin_break_cmd <= cmd_wr & wbits[UIS_CR_BEGIN_BRK];
      arm_idle_wait_cmd <= cmd_wr & wbits[UIS_CR_ARM_IDLE];
      clear_retry_count_cmd <= cmd_wr & wbits[UIS_CR_CLR_RETRY] & iso_mode;
    end
  end

  // Pending break request holds the holding-free flag low
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      break_pend <= 1'b0;
    end
    else
    begin
      // A new request wins over a start in the same cycle
      break_pend <= (cmd_wr & wbits[UIS_CR_BEGIN_BRK]) | (break_pend & ~break_started);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Receive ready

  // Remember characters that arrived while the receiver was off
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      rx_missed <= 1'b0;
    end
    else
    begin
      rx_missed <= ~rx_enabled & (rx_missed | rx_char_done);
    end
  end

  // New character wins over a read in the same cycle
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      rx_rdy <= 1'b0;
    end
    else if (rx_char_done & rx_enabled)
    begin
      rx_rdy <= 1'b1;
    end
    else if (rx_missed & rx_enabled)
    begin
      rx_rdy <= 1'b1;
    end
    else if (rx_holding_read | ~rx_enabled)
    begin
      rx_rdy <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Sticky error flags

  assign clr_err = cmd_wr & wbits[UIS_CR_CLR_ERR];

  // Events win over the clearing command
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      brk_flag <= 1'b0;
      ovr_flag <= 1'b0;
      frame_flag <= 1'b0;
      par_flag <= 1'b0;
    end
    else
    begin
      brk_flag <= (brk_flag & ~clr_err) | rx_break_seen_evt;
      ovr_flag <= (ovr_flag & ~clr_err) | rx_overrun_evt;
      frame_flag <= (frame_flag & ~clr_err) | rx_frame_evt;
      par_flag <= (par_flag & ~clr_err) | rx_parity_evt;
    end
  end

  // Receiver time-out: counts only after an arm and with a nonzero value
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      tmo_flag <= 1'b0;
      tmo_armed <= 1'b0;
    end
    else if (idle_limit == 16'h0000)
    begin
      tmo_flag <= 1'b0;
      tmo_armed <= cmd_wr & wbits[UIS_CR_ARM_IDLE];
    end
    else if (cmd_wr & wbits[UIS_CR_ARM_IDLE])
    begin
      tmo_flag <= rx_timeout_evt & tmo_armed;
      tmo_armed <= 1'b1;
    end
    else if (rx_timeout_evt & tmo_armed)
    begin
      tmo_flag <= 1'b1;
      tmo_armed <= 1'b0;
    end
  end

  // Iteration and non-acknowledge flags, events win
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      iter_flag <= 1'b0;
      card_seen_a_flag <= 1'b0;
    end
    else
    begin
      iter_flag <= (iter_flag & ~(cmd_wr & wbits[UIS_CR_CLR_RETRY] & iso_mode))
                   | iter_max_evt;
      card_seen_a_flag <= (card_seen_a_flag & ~(cmd_wr & wbits[UIS_CR_CLR_CARD_SEEN_A]))
                   | card_card_seen_a_evt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Modem lines

  // Two-stage synchronisers; the first stage feeds only the second
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      modem_meta <= 4'h0;
      modem_sync <= 4'h0;
      modem_prev <= 4'h0;
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
    end
    else
    begin
      modem_meta <= {clear_send_pin, carrier_pin, set_ready_pin, ring_line_pin};
      modem_sync <= modem_meta;
      modem_prev <= modem_sync;
      rx_meta <= rx_line_pin;
      rx_sync <= rx_meta;
    end
  end

  // Clear only the bits the read returned; an edge in its wait cycle is kept
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      modem_chg <= 4'h0;
    end
    else
    begin
      modem_chg <= (modem_chg & ~({4{rd_go & (avs_address == UIS_OFS_CSR)}}
                   & avs_readdata[UIS_ST_CHG_LO +: 4]))
                   | (modem_sync ^ modem_prev);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Receive line filter

  // Samples are taken on the sixteenth-bit tick only
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      rx_samples <= UIS_RST_SAMPLES;
    end
    else if (sample_tick)
    begin
      rx_samples <= {rx_samples[1:0], rx_sync};
    end
  end

  assign rx_major = (rx_samples[0] & rx_samples[1]) |
                    (rx_samples[1] & rx_samples[2]) |
                    (rx_samples[0] & rx_samples[2]);

  // Filtered line adds up to two ticks of delay; unfiltered is direct
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      rx_line_filtered <= 1'b1;
    end
    else
    begin
      rx_line_filtered <= mode_reg[UIS_MR_FILTER] ? rx_major : rx_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Status word and interrupt

  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[UIS_ST_RX_RDY] = rx_rdy;
    status_word[UIS_ST_TX_FREE] = tx_enabled & ~tx_holding_full & ~break_pend;
    status_word[UIS_ST_BRK] = brk_flag;
    status_word[UIS_ST_RX_END] = rx_dma_end;
    status_word[UIS_ST_TX_END] = tx_dma_end;
    status_word[UIS_ST_OVR] = ovr_flag;
    status_word[UIS_ST_FRAME] = frame_flag;
    status_word[UIS_ST_PAR] = par_flag;
    status_word[UIS_ST_TIMEOUT] = tmo_flag;
    status_word[UIS_ST_TX_EMPTY] = tx_enabled & ~tx_holding_full & ~tx_shift_busy;
    status_word[UIS_ST_ITER] = iter_flag;
    status_word[UIS_ST_TX_BUFE] = tx_dma_buf_empty;
    status_word[UIS_ST_RX_BUFF] = rx_dma_buf_full;
    status_word[UIS_ST_CARD_SEEN_A] = card_seen_a_flag;
    status_word[UIS_ST_CHG_LO +: 4] = modem_chg;
    status_word[UIS_ST_LVL_LO +: 4] = modem_sync;
  end

  // Registered request line, one cycle behind the status
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= |(status_word & irq_mask);
    end
  end

endmodule : uis_usart_irq_status

/* File: uis_irq_status_monitor.sv */
// Port-level checker for the USART interrupt and status block
module uis_irq_status_monitor
  import uis_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic rx_dma_end,
  input wire logic tx_dma_end,
  input wire logic tx_dma_buf_empty,
  input wire logic rx_dma_buf_full,
  input wire logic sample_tick,
  input wire logic rx_line_filtered,
  input wire logic rx_enabled,
  input wire logic tx_enabled,
  input wire logic begin_break_cmd,
  input wire logic arm_idle_wait_cmd,
  input wire logic clear_retry_count_cmd,
  input wire logic irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////
  logic done; // Transfer completes at this edge
  logic ctl; // Control word write completes
  logic [31:0] bm; // Byte lanes as bits
  logic [31:0] mask_q; // Shadow of the mask register
  logic [31:0] mode_q; // Shadow of the mode register
  logic [3:0] dma; // Live DMA channel levels
  logic [3:0] dma_q1;
  logic [3:0] dma_q2;
  logic [2:0] fs; // Filter on for three cycles
  logic retry_q; // Retry strobe is owed
  assign done = (avs_read | avs_write) & ~avs_waitrequest;
  assign ctl = done & avs_write & (avs_address == UIS_OFS_CTRL);
  assign bm = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign dma = {rx_dma_buf_full, tx_dma_buf_empty, tx_dma_end, rx_dma_end};
  // Shadows follow completed writes only
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
    begin
      mask_q <= UIS_RST_MASK;
      mode_q <= UIS_RST_MODE;
    end
    else if (done && avs_write)
    begin
      if (avs_address == UIS_OFS_IER)
        mask_q <= mask_q | (avs_writedata & bm & UIS_IRQ_BITS);
      if (avs_address == UIS_OFS_IDR)
        mask_q <= mask_q & ~(avs_writedata & bm);
      if (avs_address == UIS_OFS_MODE)
        mode_q <= (mode_q & ~bm) | (avs_writedata & bm);
    end
  // Level history; a mirror is judged once its input has settled
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
    begin
      dma_q1 <= 4'h0;
      dma_q2 <= 4'h0;
      fs <= 3'h0;
      retry_q <= 1'h0;
    end
    else
    begin
      dma_q1 <= dma;
      dma_q2 <= dma_q1;
      fs <= {fs[1:0], mode_q[UIS_MR_FILTER]};
      retry_q <= ctl & avs_writedata[UIS_CR_CLR_RETRY] & avs_byteenable[1] &
        (mode_q[3:0] == UIS_MODE_ISO_T0 || mode_q[3:0] == UIS_MODE_ISO_T1);
    end
  ////////////////////////////////////////////////////////////////////
  chk_wait_one: assert property
    ((avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest stayed high past one cycle");
  chk_wait_back: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  chk_mask_read: assert property (
    done && avs_read && avs_address == UIS_OFS_IMR |-> avs_readdata == mask_q)
    else $error("mask read differs from enable history");
  chk_dma_live: assert property (
    done && avs_read && avs_address == UIS_OFS_CSR && dma_q1 == dma && dma_q2 == dma
    |-> {avs_readdata[12:11], avs_readdata[4:3]} == dma)
    else $error("dma status bits do not mirror channel levels");
  chk_irq_quiet: assert property ((mask_q == 32'h0)[*2] |-> !irq)
    else $error("interrupt high with every source masked");
  chk_break_cmd: assert property (
    ctl && avs_writedata[UIS_CR_BEGIN_BRK] && avs_byteenable[1] |=> begin_break_cmd)
    else $error("break strobe missing after control write");
  chk_arm_cmd: assert property (
    ctl && avs_writedata[UIS_CR_ARM_IDLE] && avs_byteenable[1] |=> arm_idle_wait_cmd)
    else $error("arm strobe missing after control write");
  chk_retry_cmd: assert property (clear_retry_count_cmd == retry_q)
    else $error("retry strobe disagrees with command and mode");
  chk_rx_off: assert property (
    ctl && avs_writedata[UIS_CR_RXDIS] && avs_byteenable[0] |=> !rx_enabled)
    else $error("receiver still enabled after disable");
  chk_tx_on: assert property (
    ctl && avs_writedata[UIS_CR_TXEN] && !avs_writedata[UIS_CR_TXDIS] &&
    avs_byteenable[0] |=> tx_enabled)
    else $error("transmitter not enabled after enable");
  chk_filter_tick: assert property (
    (&fs) && $changed(rx_line_filtered) |-> $past(sample_tick) || $past(sample_tick, 2))
    else $error("filtered line moved without a sample tick");
  // Main scenarios reached
  cover property (ctl && avs_writedata[UIS_CR_CLR_ERR]);
  cover property ($rose(irq));
  cover property (clear_retry_count_cmd);
endmodule : uis_irq_status_monitor

bind uis_usart_irq_status uis_irq_status_monitor uis_irq_status_monitor_inst (.*);

/* File: uis_serial_peer.sv */
// Serial peer model driving the receive line and the modem control lines
module uis_serial_peer
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic slow,
  input wire logic rx_set,
  input wire logic [3:0] modem_set,
  output logic rx_line_pin,
  output logic [3:0] modem_pins
);
  timeunit 1ns;
  timeprecision 1ps;
  logic rx_d; // Lagged copy for slow answers
  logic [3:0] modem_d;
  // Lines change just after an edge; slow mode adds a cycle of lag
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
    begin
      rx_d <= 1'h1;
      modem_d <= 4'h0;
      rx_line_pin <= 1'h1;
      modem_pins <= 4'h0;
    end
    else
    begin
      rx_d <= rx_set;
      modem_d <= modem_set;
      rx_line_pin <= slow ? rx_d : rx_set;
      modem_pins <= slow ? modem_d : modem_set;
    end
endmodule : uis_serial_peer

/* File: testbench.sv */
// Self-checking bench for the USART interrupt and status block
module testbench
  import uis_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'h0;
  logic rstn = 1'h0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [10:0] ev = 11'h0; // Engine event pulses
  logic tx_holding_full = 1'h0;
  logic tx_shift_busy = 1'h0;
  logic [3:0] dma = 4'h0;
  logic rx_set = 1'h1;
  logic [3:0] modem_set = 4'h0;
  logic slow = 1'h0;
  logic rx_line_pin;
  logic [3:0] modem_pins;
  logic rx_line_filtered, rx_enabled, tx_enabled, irq;
  logic begin_break_cmd, arm_idle_wait_cmd, clear_retry_count_cmd;
  logic [63:0] notes[$]; // Expected read value and care mask
  int fails = 0;
  int comparisons = 0;
  logic [31:0] m, r;
  logic [3:0] v, old;
  int i;
  ////////////////////////////////////////////////////////////////////
  uis_usart_irq_status uis_usart_irq_status_inst (
    .rx_char_done(ev[7]),
    .rx_holding_read(ev[8]),
    .rx_break_seen_evt(ev[0]),
    .rx_overrun_evt(ev[1]),
    .rx_frame_evt(ev[2]),
    .rx_parity_evt(ev[3]),
    .rx_timeout_evt(ev[6]),
    .iter_max_evt(ev[4]),
    .card_card_seen_a_evt(ev[5]),
    .break_started(ev[9]),
    .sample_tick(ev[10]),
    .rx_dma_end(dma[0]),
    .tx_dma_end(dma[1]),
    .tx_dma_buf_empty(dma[2]),
    .rx_dma_buf_full(dma[3]),
    .ring_line_pin(modem_pins[0]),
    .set_ready_pin(modem_pins[1]),
    .carrier_pin(modem_pins[2]),
    .clear_send_pin(modem_pins[3]),
    .*
  );
  uis_serial_peer uis_serial_peer_inst (.*);
  // Free-running system clock
  initial forever #2 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  task automatic check_word(input logic [31:0] seen, input logic [63:0] note);
    comparisons++;
    if ((seen & note[31:0]) !== note[63:32])
    begin
      fails++;
      $display("mismatch readdata expected %h seen %h", note[63:32], seen & note[31:0]);
    end
  endtask : check_word
  task automatic check_bit(input string name, input logic seen, input logic exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch %s expected %b seen %b", name, exp, seen);
    end
  endtask : check_bit
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : idle
  // One Avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic rd_n, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] be);
    @(posedge clk_sys);
    avs_read <= rd_n;
    avs_write <= !rd_n;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    do
      @(posedge clk_sys);
    while (avs_waitrequest);
    avs_read <= 1'h0;
    avs_write <= 1'h0;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'h0, a, d, 4'hf);
  endtask : wr
  // The expectation is noted before the read is issued
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] k);
    notes.push_back({e, k});
    bus(1'h1, a, 32'h0, 4'h0);
  endtask : rd
  task automatic pulse(input int k);
    @(posedge clk_sys);
    ev[k] <= 1'h1;
    @(posedge clk_sys);
    ev[k] <= 1'h0;
  endtask : pulse
  // Set the line, let it sync, take one sample tick, then look
  task automatic ftick(input logic lvl, input logic exp);
    rx_set <= lvl;
    idle(6);
    pulse(10);
    idle(3);
    check_bit("rx_line_filtered", rx_line_filtered, exp);
  endtask : ftick
  function automatic logic [31:0] lanes(input logic [3:0] be);
    lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : lanes
  // Each completed read is checked against the oldest note
  always @(posedge clk_sys)
    if (avs_read && !avs_waitrequest)
      check_word(avs_readdata, notes.pop_front());
  // Watchdog cuts a hang short
  initial
  begin
    #100000;
    fails++;
    report_and_stop();
  end
  ////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'hdfe2bce8));
    idle(5);
    rstn <= 1'h1;
    // Mask: random enables and disables through random byte lanes
    rd(UIS_OFS_IMR, 32'h0, 32'hffff_ffff);
    m = 32'h0;
    for (i = 0; i < 4; i++)
    begin
      r = $urandom;
      v = 4'($urandom);
      bus(1'h0, UIS_OFS_IER, r, v);
      m = m | (r & lanes(v) & 32'h000f_3fff);
      rd(UIS_OFS_IMR, m, 32'hffff_ffff);
      r = $urandom;
      bus(1'h0, UIS_OFS_IDR, r, v);
      m = m & ~(r & lanes(v));
      rd(UIS_OFS_IMR, m, 32'hffff_ffff);
    end
    rd(8'h40, 32'h0, 32'hffff_ffff);
    rd(UIS_OFS_IER, 32'h0, 32'hffff_ffff);
    $display("test mask done");
    // Sticky flags and the commands that clear them
    for (i = 0; i < 6; i++)
      pulse(i);
    pulse(1);
    rd(UIS_OFS_CSR, 32'h24e4, 32'h24e4);
    wr(UIS_OFS_CTRL, 32'h100);
    rd(UIS_OFS_CSR, 32'h2400, 32'h24e4);
    wr(UIS_OFS_CTRL, 32'h4000);
    rd(UIS_OFS_CSR, 32'h0400, 32'h24e4);
    wr(UIS_OFS_CTRL, 32'h2000);
    rd(UIS_OFS_CSR, 32'h0400, 32'h24e4);
    for (i = 0; i < 2; i++)
    begin
      wr(UIS_OFS_MODE, {28'h0, i ? UIS_MODE_ISO_T1 : UIS_MODE_ISO_T0});
      pulse(4);
      wr(UIS_OFS_CTRL, 32'h2000);
      rd(UIS_OFS_CSR, 32'h0, 32'h0400);
    end
    wr(UIS_OFS_MODE, 32'h0);
    $display("test sticky done");
    // Time-out: zero value holds the flag off, arm clears it
    wr(UIS_OFS_CTRL, 32'h800);
    pulse(6);
    rd(UIS_OFS_CSR, 32'h0, 32'h100);
    wr(UIS_OFS_RTOR, 32'h5);
    rd(UIS_OFS_RTOR, 32'h5, 32'hffff_ffff);
    wr(UIS_OFS_CTRL, 32'h800);
    pulse(6);
    rd(UIS_OFS_CSR, 32'h100, 32'h100);
    wr(UIS_OFS_CTRL, 32'h800);
    rd(UIS_OFS_CSR, 32'h0, 32'h100);
    $display("test timeout done");
    // Receiver ready, including a character taken while disabled
    wr(UIS_OFS_CTRL, 32'h10);
    pulse(7);
    rd(UIS_OFS_CSR, 32'h1, 32'h1);
    pulse(8);
    rd(UIS_OFS_CSR, 32'h0, 32'h1);
    wr(UIS_OFS_CTRL, 32'h20);
    pulse(7);
    rd(UIS_OFS_CSR, 32'h0, 32'h1);
    wr(UIS_OFS_CTRL, 32'h10);
    rd(UIS_OFS_CSR, 32'h1, 32'h1);
    // Transmitter ready and empty
    rd(UIS_OFS_CSR, 32'h0, 32'h202);
    wr(UIS_OFS_CTRL, 32'h40);
    rd(UIS_OFS_CSR, 32'h202, 32'h202);
    tx_holding_full <= 1'h1;
    rd(UIS_OFS_CSR, 32'h0, 32'h202);
    tx_holding_full <= 1'h0;
    tx_shift_busy <= 1'h1;
    rd(UIS_OFS_CSR, 32'h2, 32'h202);
    tx_shift_busy <= 1'h0;
    wr(UIS_OFS_CTRL, 32'h200);
    rd(UIS_OFS_CSR, 32'h0, 32'h2);
    pulse(9);
    rd(UIS_OFS_CSR, 32'h202, 32'h202);
    wr(UIS_OFS_CTRL, 32'hc0);
    rd(UIS_OFS_CSR, 32'h0, 32'h202);
    $display("test ready done");
    // Interrupt line follows an enabled flag, then the mask
    wr(UIS_OFS_IDR, 32'hffff_ffff);
    wr(UIS_OFS_IER, 32'h20);
    idle(3);
    check_bit("irq", irq, 1'h0);
    pulse(1);
    idle(3);
    check_bit("irq", irq, 1'h1);
    wr(UIS_OFS_IDR, 32'h20);
    idle(3);
    check_bit("irq", irq, 1'h0);
    $display("test irq done");
    // DMA channel levels mirrored live
    for (i = 0; i < 8; i++)
    begin
      v = 4'($urandom);
      dma <= v;
      rd(UIS_OFS_CSR, {19'h0, v[3:2], 6'h0, v[1:0], 3'h0}, 32'h1818);
    end
    $display("test dma done");
    // Modem lines: images and change flags cleared by the read
    rd(UIS_OFS_CSR, 32'h0, 32'h00ff_0000);
    old = 4'h0;
    for (i = 0; i < 6; i++)
    begin
      v = 4'($urandom);
      slow <= v[0] ^ v[3];
      modem_set <= v;
      idle(6);
      rd(UIS_OFS_CSR, {8'h0, v, v ^ old, 16'h0}, 32'h00ff_0000);
      rd(UIS_OFS_CSR, {8'h0, v, 20'h0}, 32'h00ff_0000);
      old = v;
    end
    $display("test modem done");
    // Receive filter: off follows the line, on takes 2 of 3 samples
    ftick(1'h0, 1'h0);
    ftick(1'h1, 1'h1);
    wr(UIS_OFS_MODE, 32'h1000_0000);
    rd(UIS_OFS_MODE, 32'h1000_0000, 32'hffff_ffff);
    for (i = 0; i < 8; i++)
      ftick(1'(8'h47 >> i), 1'(8'h0f >> i));
    $display("test filter done");
    report_and_stop();
  end
endmodule : testbench
